// *** design/discrete_output_flash_control.sv ***
`timescale 1ns/1ps
// Functional notes
// R1 - relay variant: command bits of outputs 1-16 are coils 001-016, 017-032 unused
// R2 - relay variant: flash enables of outputs 1-16 are coils 033-048, 049-064 unused
// R3 - transistor variant: command bits of outputs 1-32 are coils 001-032
// R4 - transistor variant: flash enables of outputs 1-32 are coils 033-064
// R5 - holding register 131 holds flash on and off half-period in 10 ms units
// R6 - half-period spans full 16 bits, 0 to 655.35 s, 10 ms steps
// R7 - no read-only status bits are implemented for this block
// R8 - no read-only input registers are implemented for this block
// R9 - per output: command bit turns it on, flash bit makes it flash when on
// R10 - flash timing is generated locally, independent of bus traffic; a write to holding register 131 restarts the phase here
// R11 - local force on/off per output overrides the master command
// R12 - indicator shows the state actually driving the field output
// R13 - half-period of zero means no flashing, output steadily on
module discrete_output_flash_control
  import dout_flash_pkg::*;
#(
  parameter int unsigned NUM_OUT     = 32,
  parameter int unsigned TICK_CYCLES_P = TICK_CYCLES
) (
  input  wire logic                   core_clk,
  input  wire logic                   rst,
  input  wire logic                   req_valid,
  input  wire logic                   req_write,
  input  wire reg_space_t             req_space,
  input  wire logic [15:0]            req_number,
  input  wire logic [15:0]            req_wdata,
  output logic                        rsp_valid,
  output logic                        rsp_error,
  output logic [15:0]                 rsp_rdata,
  input  wire logic [2*NUM_OUT-1:0]   force_code,
  output logic [NUM_OUT-1:0]          field_out,
  output logic [NUM_OUT-1:0]          led_out,
  output logic [15:0]                 flash_half_period
);
  // only the two bank sizes exist; any other width would leave the coil
  // windows half mapped, so it is refused while elaborating
  if (NUM_OUT != 16 && NUM_OUT != 32) begin : g_bad_num_out
    $error("discrete_output_flash_control: NUM_OUT must be 16 or 32");
  end
  // the timebase needs at least two cycles to form a one-cycle tick
  if (TICK_CYCLES_P < 2) begin : g_bad_tick
    $error("discrete_output_flash_control: TICK_CYCLES_P must be at least 2");
  end

  localparam int unsigned IDX_W = $clog2(NUM_OUT);

  // one phase counter is shared by every output, so all flashing outputs
  // blink together; per-output phases would cost a counter per channel
  typedef struct packed {
    logic [NUM_OUT-1:0] cmd;
    logic [NUM_OUT-1:0] flash_en;
    logic [15:0]        half;
    logic [15:0]        phase_cnt;
    logic               phase_on;
    logic               rsp_valid;
    logic               rsp_error;
    logic [15:0]        rsp_rdata;
    logic [NUM_OUT-1:0] field;
  } ctl_state_t;

  ctl_state_t st_reg;
  ctl_state_t st_next;
  logic       tick;
  logic [NUM_OUT-1:0] drive;

  // the tick runs free from reset, so of all bus traffic only a half-period write restarts a phase
  flash_timebase #(
    .CYCLES (TICK_CYCLES_P)
  ) u_timebase (
    .core_clk (core_clk),
    .rst      (rst),
    .tick     (tick)
  );

  // per-output drive: force first, else command gated by the shared flash phase
  genvar g;
  generate
    for (g = 0; g < NUM_OUT; g++) begin : g_out
      logic [1:0] code;
      logic       flash_live;
      // code 11 has no meaning; it falls through to the master command
      assign code       = force_code[2*g +: 2];
      assign flash_live = st_reg.flash_en[g] && (st_reg.half != 16'h0000);
      always_comb begin
        if (code == FORCE_ON) begin
          drive[g] = 1'b1; // R11
        end else if (code == FORCE_OFF) begin
          drive[g] = 1'b0; // R11
        end else if (flash_live) begin
          drive[g] = st_reg.cmd[g] & st_reg.phase_on; // R9
        end else begin
          drive[g] = st_reg.cmd[g]; // R13
        end
      end
    end
  endgenerate

  // request decode; the windows are tested on the full 16-bit number so a
  // large number can never alias onto a low coil through the short index
  logic [15:0]      cmd_off;
  logic [15:0]      flash_off;
  logic [IDX_W-1:0] cmd_idx;
  logic [IDX_W-1:0] flash_idx;
  logic             in_cmd;
  logic             in_flash;
  logic             in_hold;
  logic             cmd_bit;
  logic             flash_bit;
  always_comb begin
    cmd_off   = req_number - COIL_CMD_FIRST;
    flash_off = req_number - COIL_FLASH_FIRST;
    cmd_idx   = cmd_off[IDX_W-1:0];
    flash_idx = flash_off[IDX_W-1:0];
    // unused coils 017-032 and 049-064 of the 16-output build fall outside these
    in_cmd    = (req_number >= COIL_CMD_FIRST) &&
                (req_number < COIL_CMD_FIRST + 16'(NUM_OUT)); // R1 R3
    in_flash  = (req_number >= COIL_FLASH_FIRST) &&
                (req_number < COIL_FLASH_FIRST + 16'(NUM_OUT)); // R2 R4
    in_hold   = (req_space == SPACE_HOLDING) && (req_number == HREG_FLASH_HALF); // R5
    cmd_bit   = st_reg.cmd[cmd_idx];
    flash_bit = st_reg.flash_en[flash_idx];
  end

  // write strobes; a refused request changes no state
  logic coil_req;
  logic wr_cmd;
  logic wr_flash;
  logic wr_hold;
  always_comb begin
    coil_req = req_valid && (req_space == SPACE_COIL);
    wr_cmd   = coil_req && req_write && in_cmd;
    wr_flash = coil_req && req_write && in_flash;
    wr_hold  = req_valid && req_write && in_hold;
  end

  // end of a half-period: the phase counter has seen half ticks
  logic phase_end;
  always_comb begin
    phase_end = tick && (st_reg.phase_cnt >= st_reg.half - 16'h0001); // R5 R6
  end

  always_comb begin
    st_next           = st_reg;
    st_next.rsp_valid = 1'b0;
    st_next.rsp_error = 1'b0;
    st_next.rsp_rdata = 16'h0000;
    st_next.field     = drive;

    // flash phase advances only on the local tick
    if (st_reg.half == 16'h0000) begin
      st_next.phase_cnt = 16'h0000; // R13
      st_next.phase_on  = 1'b1;
    end else if (phase_end) begin // R10
      st_next.phase_cnt = 16'h0000; // R5 R6
      st_next.phase_on  = ~st_reg.phase_on;
    end else if (tick) begin // R10
      st_next.phase_cnt = st_reg.phase_cnt + 16'h0001;
    end

    // every accepted answer carries the value held before this request, writes too; a refused one carries zero
    if (req_valid) begin
      st_next.rsp_valid = 1'b1;
      if (coil_req && in_cmd) begin
        st_next.rsp_rdata = {15'h0000, cmd_bit}; // R1 R3
      end else if (coil_req && in_flash) begin
        st_next.rsp_rdata = {15'h0000, flash_bit}; // R2 R4
      end else if (in_hold) begin
        st_next.rsp_rdata = st_reg.half; // R5
      end else begin
        st_next.rsp_error = 1'b1; // R7 R8
      end
    end
    if (wr_cmd) begin
      st_next.cmd[cmd_idx] = req_wdata[0]; // R1 R3
    end
    if (wr_flash) begin
      st_next.flash_en[flash_idx] = req_wdata[0]; // R2 R4
    end
    // placed after the phase update so a new rate wins over a tick
    if (wr_hold) begin
      st_next.half      = req_wdata; // R5 R6
      // restart the cycle so a new rate starts with a clean on phase
      st_next.phase_cnt = 16'h0000;
      st_next.phase_on  = 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_reg          <= '0;
      st_reg.half     <= FLASH_HALF_RESET;
      st_reg.phase_on <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // every output is a flip-flop of the state; the field drive and the
  // indicator share one register so they can never disagree
  assign rsp_valid         = st_reg.rsp_valid;
  assign rsp_error         = st_reg.rsp_error;
  assign rsp_rdata         = st_reg.rsp_rdata;
  assign field_out         = st_reg.field;
  assign led_out           = st_reg.field; // R12
  assign flash_half_period = st_reg.half;
endmodule // discrete_output_flash_control

// *** design/dout_flash_pkg.sv ***
package dout_flash_pkg;
  // coil numbers (1-based) and holding register number
  localparam logic [15:0] COIL_CMD_FIRST   = 16'h0001;
  localparam logic [15:0] COIL_FLASH_FIRST = 16'h0021;
  localparam logic [15:0] COIL_BANK_SPAN   = 16'h0020;
  localparam logic [15:0] HREG_FLASH_HALF  = 16'h0083;
  localparam logic [15:0] FLASH_HALF_RESET = 16'h0000;
  // timebase
  localparam int unsigned CLK_HZ           = 20000000;
  localparam int unsigned TICK_MS          = 10;
  localparam int unsigned TICK_CYCLES      = CLK_HZ / 1000 * TICK_MS;
  // local force codes
  localparam logic [1:0]  FORCE_NONE       = 2'h0;
  localparam logic [1:0]  FORCE_ON         = 2'h1;
  localparam logic [1:0]  FORCE_OFF        = 2'h2;
  // register access port kinds
  typedef enum logic [1:0] {
    SPACE_COIL    = 2'b00,
    SPACE_STATUS  = 2'b01,
    SPACE_INPUT   = 2'b10,
    SPACE_HOLDING = 2'b11
  } reg_space_t;
endpackage

// *** design/flash_timebase.sv ***
`timescale 1ns/1ps
// free-running 10 ms tick, independent of any bus traffic
module flash_timebase
  import dout_flash_pkg::*;
#(
  parameter int unsigned CYCLES = TICK_CYCLES
) (
  input  wire logic core_clk,
  input  wire logic rst,
  output logic      tick
);
  // a one-cycle tick needs a counter of at least two states
  if (CYCLES < 2) begin : g_bad_cycles
    $error("flash_timebase: CYCLES must be at least 2");
  end

  typedef struct packed {
    logic [31:0] cnt;
    logic        tick;
  } tb_state_t;

  tb_state_t st_reg;
  tb_state_t st_next;

  always_comb begin
    st_next      = st_reg;
    st_next.tick = 1'b0;
    if (st_reg.cnt == 32'(CYCLES - 1)) begin
      st_next.cnt  = 32'h0000_0000;
      st_next.tick = 1'b1;
    end else begin
      st_next.cnt = st_reg.cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign tick = st_reg.tick;
endmodule // flash_timebase

// *** verif/discrete_output_flash_control_tb.sv ***
`timescale 1ns/1ps
module discrete_output_flash_control_tb;
  import dout_flash_pkg::*;
  localparam int unsigned NUM_OUT = 16;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic req_valid, req_write, rsp_valid, rsp_error;
  reg_space_t req_space;
  logic [15:0] req_number, req_wdata, rsp_rdata, flash_half_period;
  logic [2*NUM_OUT-1:0] force_code = '0;
  logic [NUM_OUT-1:0] field_out, led_out;
  logic [16:0] exp_q[$];
  logic [31:0] lfsr = 32'h633D;
  int mismatches = 0;
  int num_checks = 0;
  int cnt;
  logic exp_bit;
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  initial forever #25 core_clk = ~core_clk;
  modbus_master_model i_modbus_master_model (.*);
  discrete_output_flash_control #(.NUM_OUT(NUM_OUT), .TICK_CYCLES_P(4))
    i_discrete_output_flash_control (.*);
  task automatic check(input logic [16:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic req(input logic w, reg_space_t s, logic [15:0] n, d, logic [16:0] e);
    exp_q.push_back(e);
    i_modbus_master_model.send(w, s, n, d);
  endtask
  task automatic cnt_on(input int n);
    cnt = 0;
    repeat (n) @(posedge core_clk) cnt += int'(field_out[0]);
  endtask
  // rdata is don't-care on a refused request
  always @(posedge core_clk) if (rsp_valid === 1'b1) begin
    if (exp_q.size() == 0) check(17'h1FFFF, 17'h00000);
    else check({rsp_error, rsp_error ? 16'h0000 : rsp_rdata}, exp_q.pop_front());
  end
  initial begin
    #2000000;
    mismatches++;
    end_sim();
  end
  initial begin
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    check({1'b0, flash_half_period}, {1'b0, FLASH_HALF_RESET});
    req(1, SPACE_COIL, 16'h0001, 16'h0001, 17'h00000);
    req(0, SPACE_COIL, 16'h0001, 16'h0000, 17'h00001);
    req(1, SPACE_COIL, 16'h0021, 16'h0001, 17'h00000);
    req(1, SPACE_COIL, 16'h0011, 16'h0001, 17'h10000);
    req(0, SPACE_COIL, 16'h0031, 16'h0000, 17'h10000);
    req(0, SPACE_STATUS, 16'h0001, 16'h0000, 17'h10000);
    req(0, SPACE_INPUT, 16'h0001, 16'h0000, 17'h10000);
    req(0, SPACE_HOLDING, 16'h0082, 16'h0000, 17'h10000);
    req(1, SPACE_HOLDING, HREG_FLASH_HALF, 16'h0002, 17'h00000);
    req(0, SPACE_HOLDING, HREG_FLASH_HALF, 16'h0000, 17'h00002);
    i_modbus_master_model.idle();
    check({1'b0, flash_half_period}, 17'h00002);
    $display("register test done");
    repeat (40) @(posedge core_clk);
    cnt_on(16);
    check(17'(cnt), 17'h00008);
    req(1, SPACE_HOLDING, HREG_FLASH_HALF, 16'h0000, 17'h00002);
    i_modbus_master_model.idle();
    repeat (4) @(posedge core_clk);
    cnt_on(16);
    check(17'(cnt), 17'h00010);
    $display("flash test done");
    repeat (4) begin
      lfsr = lfsr_next(lfsr);
      force_code <= lfsr;
      repeat (2) @(posedge core_clk);
      for (int i = 0; i < NUM_OUT; i++) begin
        exp_bit = lfsr[2*i+:2] == FORCE_ON ? 1'b1 :
          lfsr[2*i+:2] == FORCE_OFF ? 1'b0 : i == 0;
        check(17'(field_out[i]), 17'(exp_bit));
        check(17'(led_out[i]), 17'(exp_bit));
      end
    end
    $display("force test done");
    force_code <= '0;
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    check(17'(field_out), 17'h00000);
    check({1'b0, flash_half_period}, {1'b0, FLASH_HALF_RESET});
    rst <= 1'b0;
    req(0, SPACE_COIL, 16'h0001, 16'h0000, 17'h00000);
    i_modbus_master_model.idle();
    repeat (4) @(posedge core_clk);
    $display("reset test done");
    end_sim();
  end
endmodule // discrete_output_flash_control_tb

// *** verif/dout_flash_checker.sv ***
`timescale 1ns/1ps
module dout_flash_checker
  import dout_flash_pkg::*;
#(parameter int unsigned NUM_OUT = 32) (
  input wire logic                 core_clk,
  input wire logic                 rst,
  input wire logic                 req_valid,
  input wire logic                 req_write,
  input wire reg_space_t           req_space,
  input wire logic [15:0]          req_number,
  input wire logic [15:0]          req_wdata,
  input wire logic                 rsp_valid,
  input wire logic                 rsp_error,
  input wire logic [2*NUM_OUT-1:0] force_code,
  input wire logic [NUM_OUT-1:0]   field_out,
  input wire logic [NUM_OUT-1:0]   led_out,
  input wire logic [15:0]          flash_half_period
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  logic coil_req;
  assign coil_req = req_valid && req_space == SPACE_COIL;
  rsp_lat_a: assert property (req_valid |=> rsp_valid) else $error("no answer");
  ro_space_a: assert property (req_valid && req_space inside {SPACE_STATUS, SPACE_INPUT}
    |=> rsp_error) else $error("ro space taken");
  coil_gap_a: assert property (coil_req && req_number inside {[NUM_OUT+1:32]}
    |=> rsp_error) else $error("gap coil taken");
  flash_map_a: assert property (coil_req && req_number inside {[33:32+NUM_OUT]}
    |=> !rsp_error) else $error("flash coil refused");
  hreg_wr_a: assert property (req_valid && req_write && req_space == SPACE_HOLDING
    && req_number == HREG_FLASH_HALF |=> !rsp_error ##1
    flash_half_period == $past(req_wdata, 2)) else $error("period not stored");
  force_on_a: assert property (force_code[1:0] == FORCE_ON |=> field_out[0])
    else $error("force on lost");
  force_off_a: assert property (force_code[1:0] == FORCE_OFF |=> !field_out[0])
    else $error("force off lost");
  led_mirror_a: assert property (led_out == field_out) else $error("led differs");
  cover property (rsp_valid && rsp_error);
  cover property (req_valid && req_write && req_space == SPACE_HOLDING);
  cover property (field_out[0] ##1 !field_out[0]);
endmodule // dout_flash_checker
bind discrete_output_flash_control dout_flash_checker #(.NUM_OUT(NUM_OUT)) i_chk (.*);

// *** verif/modbus_master_model.sv ***
`timescale 1ns/1ps
module modbus_master_model
  import dout_flash_pkg::*;
(
  input wire logic    core_clk,
  output logic        req_valid = 1'b0,
  output logic        req_write = 1'b0,
  output reg_space_t  req_space = SPACE_COIL,
  output logic [15:0] req_number = 16'h0000,
  output logic [15:0] req_wdata = 16'h0000
);
  // valid stays high across back-to-back sends; idle drops it
  task automatic send(input logic w, input reg_space_t s, input logic [15:0] n, d);
    @(posedge core_clk);
    req_valid <= 1'b1;
    req_write <= w;
    req_space <= s;
    req_number <= n;
    req_wdata <= d;
  endtask
  task automatic idle();
    @(posedge core_clk);
    req_valid <= 1'b0;
    req_number <= ~req_number;
  endtask
endmodule // modbus_master_model
